// ==== rtl/pgr_pkg.sv ====
// Constants shared by the program counter and general register file.
// Assumes a single 20 MHz clock and an APB master on the register side.
package pgr_pkg;

    localparam int DATA_W = 16;
    localparam int NUM_REGS = 16;
    localparam int ADDR_W = 4;
    localparam int APB_AW = 12;

    // Register offsets on the APB side, byte addresses.
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_PC2 = 12'h004;
    localparam logic [11:0] OFS_PC1 = 12'h008;
    localparam logic [11:0] OFS_RDIDX = 12'h00C;

    localparam logic CTRL_CONSOLE_RST = 1'b0;
    localparam logic [15:0] PC_RST = 16'h0000;

    // Status word bit positions.
    localparam int PS_CUR_HI = 15;
    localparam int PS_CUR_LO = 14;
    localparam int PS_PREV_HI = 13;
    localparam int PS_PREV_LO = 12;
    localparam int PS_SET = 11;

    // Address-select field codes.
    localparam logic [2:0] PAD_AA = 3'h0;
    localparam logic [2:0] PAD_AB = 3'h1;
    localparam logic [2:0] PAD_CC = 3'h2;
    localparam logic [2:0] PAD_UNUSED = 3'h3;
    localparam logic [2:0] PAD_ODD = 3'h4;
    localparam logic [2:0] PAD_BB = 3'h5;
    localparam logic [2:0] PAD_OFF = 3'h6;
    localparam logic [2:0] PAD_DD = 3'h7;

    // Second-stage load codes.
    localparam logic [1:0] PCB_ALWAYS = 2'h1;
    localparam logic [1:0] PCB_IF_SRC = 2'h2;
    localparam logic [1:0] PCB_IF_DST = 2'h3;

    localparam logic [2:0] IDX_PC = 3'h7;
    localparam logic [2:0] IDX_SP = 3'h6;
    localparam logic [2:0] IDX_C = 3'h5;

endpackage : pgr_pkg

// ==== rtl/pgr_rf_if.sv ====
// Carrier between the selection logic and the duplicated register storage.
// Assumes both ends share the block clock.
interface pgr_rf_if #(
    parameter int DW = 16
);
    logic [3:0] src_addr;
    logic [3:0] dst_addr;
    logic [DW-1:0] wdata;
    logic wr_lo_n;
    logic wr_hi_n;
    logic [DW-1:0] src_rdata;
    logic [DW-1:0] dst_rdata;

    modport ctrl (
        output src_addr, dst_addr, wdata, wr_lo_n, wr_hi_n,
        input src_rdata, dst_rdata
    );
    modport store (
        input src_addr, dst_addr, wdata, wr_lo_n, wr_hi_n,
        output src_rdata, dst_rdata
    );
endinterface : pgr_rf_if

// ==== rtl/pgr_regstore.sv ====
// Two storage copies of the general registers with byte write enables.
// Assumes write enables are already gated against register 7.
module pgr_regstore #(
    parameter int DW = 16,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    pgr_rf_if.store rif
);
    import pgr_pkg::*;

    logic [DW-1:0] src_copy_q [DEPTH];
    logic [DW-1:0] dst_copy_q [DEPTH];

    if (DEPTH != (1 << ADDR_W) || DW % 8 != 0) begin : g_bad_size
        $error("pgr_regstore: depth must be 16 and width whole bytes");
    end

    // Both copies are written from one address and one value, so they never differ.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                src_copy_q[i] <= '0;
                dst_copy_q[i] <= '0;
            end
        end else begin
            if (!rif.wr_lo_n) begin
                src_copy_q[rif.dst_addr][7:0] <= rif.wdata[7:0]; // [RULE7] [RULE8]
                dst_copy_q[rif.dst_addr][7:0] <= rif.wdata[7:0]; // [RULE10]
            end
            if (!rif.wr_hi_n) begin
                src_copy_q[rif.dst_addr][DW-1:8] <= rif.wdata[DW-1:8]; // [RULE7]
                dst_copy_q[rif.dst_addr][DW-1:8] <= rif.wdata[DW-1:8]; // [RULE10]
            end
        end
    end

    // Reads use independent addresses and are combinational.
    assign rif.src_rdata = src_copy_q[rif.src_addr]; // [RULE8] [RULE21]
    assign rif.dst_rdata = dst_copy_q[rif.dst_addr]; // [RULE6]

endmodule : pgr_regstore

// ==== rtl/pgr_top.sv ====
// Program counter stages, read address selection and general registers.
// Assumes phase pulses and microword fields come from logic on pclk.
//
// What this block does
// RULE1: First stage loads ALU result at T5 when enabled.
// RULE2: Second stage copies first at T1 per code.
// RULE3: Specifier seven always means the hardware counter.
// RULE4: Specifier six selects mode stack pointer 6/16/17; input B outside console mode gives 16 in user mode.
// RULE5: Specifiers zero to five pick set by bit 11.
// RULE6: Sixteen registers in two read copies, seven excluded.
// RULE7: Every write updates both copies identically.
// RULE8: Independent read addresses, shared write address.
// RULE9: Register seven reads return the second stage.
// RULE10: Separate active-low byte enables; four-bit addresses.
// RULE11: Microprogram never issues select value three.
// RULE12: Select six drives all read index bits low. The code drives bits 2:0 low and takes bit 3 from the set bit of input C.
// RULE13: Select field picks A, B, C, D inputs.
// RULE14: Input A from source field with mode bit.
// RULE15: Select four ORs force-odd into A bit zero.
// RULE16: Input B from destination field with conditions.
// RULE17: Input C presents constant index five.
// RULE18: Input D presents six or seven by bit 15.
// RULE19: Bit 14 marks supervisor or user mode.
// RULE20: Bit 11 is the register set selector.
// RULE21: Read data is combinational from current addresses.
//
// Local design decisions: register access over APB and the register addresses.
module pgr_top #(
    parameter int DATA_W = pgr_pkg::DATA_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pgr_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic phase_t1,
    input wire logic phase_t5,
    input wire logic [DATA_W-1:0] alu_result,
    input wire logic pc_stage_one_load,
    input wire logic [1:0] pc_stage_two_code,
    input wire logic [15:0] instruction_reg,
    input wire logic i_class,
    input wire logic microword_write_qualifier,
    input wire logic move_previous,
    input wire logic [15:0] status_word,
    input wire logic [2:0] addr_select,
    input wire logic force_odd_index,
    input wire logic low_byte_write_enable_n,
    input wire logic high_byte_write_enable_n,
    input wire logic [DATA_W-1:0] shifter_unit,
    output logic [DATA_W-1:0] pc_stage_two,
    output logic [DATA_W-1:0] src_read_data,
    output logic [DATA_W-1:0] dst_read_data,
    output logic [3:0] src_reg_index,
    output logic [3:0] dst_reg_index,
    output logic first_stage_load_strobe,
    output logic second_stage_load_strobe
);
    import pgr_pkg::*;

    if (DATA_W != 16) begin : g_bad_width
        $error("pgr_top: the datapath is sixteen bits wide");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Route function: picks {is_pc, set, index} for one multiplexer.

    function automatic logic [4:0] route(
        input logic [2:0] pad,
        input logic is_dst,
        input logic [4:0] in_a,
        input logic [4:0] in_b,
        input logic [4:0] in_c,
        input logic [4:0] in_d
    );
        logic [4:0] r;
        r = in_a;
        case (pad)
            PAD_AA, PAD_ODD: r = in_a; // [RULE13]
            PAD_AB: r = is_dst ? in_b : in_a; // [RULE13]
            PAD_CC: r = in_c; // [RULE13]
            PAD_BB: r = in_b; // [RULE13]
            PAD_DD: r = in_d; // [RULE13]
            PAD_OFF: r = {1'b0, in_c[3], 3'h0}; // [RULE12]
            default: r = in_a;
        endcase
        return r;
    endfunction : route

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter stages.

    logic [DATA_W-1:0] pc_stage_one_q;
    logic [DATA_W-1:0] pc_stage_two_q;
    logic [2:0] src_field;
    logic [2:0] dst_field;
    logic pcb_cond;

    assign src_field = instruction_reg[8:6];
    assign dst_field = instruction_reg[2:0];

    always_comb begin
        case (pc_stage_two_code)
            PCB_ALWAYS: pcb_cond = 1'b1; // [RULE2]
            PCB_IF_SRC: pcb_cond = (src_field == IDX_PC); // [RULE2]
            PCB_IF_DST: pcb_cond = (dst_field == IDX_PC)
                && !(i_class && microword_write_qualifier); // [RULE2]
            default: pcb_cond = 1'b0;
        endcase
    end

    assign first_stage_load_strobe = phase_t5 && pc_stage_one_load;
    assign second_stage_load_strobe = phase_t1 && pcb_cond;

    // The ALU is the only source of the first stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_stage_one_q <= PC_RST;
        end else if (first_stage_load_strobe) begin
            pc_stage_one_q <= alu_result; // [RULE1]
        end
    end

    // The second stage sees nothing but the first stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_stage_two_q <= PC_RST;
        end else if (second_stage_load_strobe) begin
            pc_stage_two_q <= pc_stage_one_q; // [RULE1] [RULE2]
        end
    end

    assign pc_stage_two = pc_stage_two_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode and multiplexer inputs.

    logic console_q;
    logic mode_cur_hi;
    logic mode_super_user;
    logic reg_set;
    logic dst_mode0;
    logic set_a;
    logic set_b;
    logic set_force;
    logic [2:0] idx_a;
    logic [2:0] idx_b;
    logic [4:0] in_a;
    logic [4:0] in_b;
    logic [4:0] in_c;
    logic [4:0] in_d;
    logic [4:0] src_route;
    logic [4:0] dst_route;

    assign mode_cur_hi = status_word[PS_CUR_HI];
    assign mode_super_user = status_word[PS_CUR_LO]; // [RULE19]
    assign reg_set = status_word[PS_SET]; // [RULE20]
    assign dst_mode0 = (instruction_reg[5:3] == 3'h0);

    // Low registers follow the set bit; register 6 in super or user uses set one.
    assign set_a = !console_q && ((reg_set && src_field < IDX_SP)
        || (mode_super_user && src_field == IDX_SP)); // [RULE4] [RULE5]
    assign set_b = !console_q && ((reg_set && dst_field < IDX_SP)
        || (mode_super_user && dst_field == IDX_SP)
        || (move_previous && microword_write_qualifier
            && dst_field >= IDX_SP && mode_super_user)); // [RULE4] [RULE5]
    assign set_force = (console_q && instruction_reg[3])
        || (move_previous && dst_mode0 && dst_field == IDX_SP
            && microword_write_qualifier && status_word[PS_PREV_LO]);

    always_comb begin
        idx_a = {src_field[2:1], 1'b0};
        if (instruction_reg[6]) begin
            idx_a[0] = 1'b1; // [RULE14]
        end else begin
            idx_a[0] = mode_cur_hi && src_field[2:1] == 2'b11; // [RULE14] [RULE4]
        end
        if (addr_select == PAD_ODD) begin
            idx_a[0] = idx_a[0] | force_odd_index; // [RULE15]
        end
    end

    // In console mode, the odd partner of a destination register 6 selects the user or previous stack; otherwise bit zero follows destination field bit zero.
    always_comb begin
        idx_b = {dst_field[2:1], 1'b0};
        if (instruction_reg[0]) begin
            idx_b[0] = 1'b1; // [RULE16]
        end else if (!console_q || dst_field != IDX_SP) begin
            idx_b[0] = 1'b0; // [RULE16]
        end else if (move_previous && dst_mode0) begin
            idx_b[0] = status_word[PS_PREV_HI]; // [RULE16]
        end else begin
            idx_b[0] = mode_cur_hi; // [RULE16]
        end
    end

    assign in_a = {src_field == IDX_PC, set_a | set_force, idx_a}; // [RULE3]
    assign in_b = {dst_field == IDX_PC, set_b | set_force, idx_b}; // [RULE3]
    assign in_c = {1'b0, reg_set | set_force, IDX_C}; // [RULE17]
    assign in_d = {1'b0, mode_super_user | set_force, IDX_SP[2:1], mode_cur_hi}; // [RULE18]

    // Select value three is never issued; it falls back to input A.
    assign src_route = route(addr_select, 1'b0, in_a, in_b, in_c, in_d); // [RULE11]
    assign dst_route = route(addr_select, 1'b1, in_a, in_b, in_c, in_d);

    assign src_reg_index = src_route[3:0];
    assign dst_reg_index = dst_route[3:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Storage and read path.

    pgr_rf_if #(.DW(DATA_W)) rif ();

    assign rif.src_addr = src_route[3:0]; // [RULE8]
    assign rif.dst_addr = dst_route[3:0]; // [RULE8]
    assign rif.wdata = shifter_unit;
    // Writes aimed at the counter never reach storage.
    assign rif.wr_lo_n = low_byte_write_enable_n | dst_route[4]; // [RULE3] [RULE10]
    assign rif.wr_hi_n = high_byte_write_enable_n | dst_route[4]; // [RULE3] [RULE10]

    pgr_regstore #(
        .DW(DATA_W),
        .DEPTH(NUM_REGS)
    ) u_store (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif)
    );

    // The counter reads return the second stage instead of a stored copy.
    assign src_read_data = src_route[4] ? pc_stage_two_q : rif.src_rdata; // [RULE9] [RULE21]
    assign dst_read_data = dst_route[4] ? pc_stage_two_q : rif.dst_rdata; // [RULE9] [RULE21]

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, read data captured in the setup cycle.

    logic apb_setup;
    logic apb_access;
    logic addr_hit;
    logic [31:0] rd_d;

    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign pready = 1'b1;

    always_comb begin
        addr_hit = 1'b1;
        rd_d = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: rd_d = {31'h0000_0000, console_q};
            OFS_PC2: rd_d = {16'h0000, pc_stage_two_q};
            OFS_PC1: rd_d = {16'h0000, pc_stage_one_q};
            OFS_RDIDX: rd_d = {14'h0000, dst_route[4], src_route[4],
                4'h0, dst_route[3:0], 4'h0, src_route[3:0]};
            default: addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_d;
        end
    end

    assign pslverr = apb_access && !addr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            console_q <= CTRL_CONSOLE_RST;
        end else if (apb_access && pwrite && paddr == OFS_CTRL && pstrb[0]) begin
            console_q <= pwdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pca_load_a: assert property (first_stage_load_strobe |=> // [RULE1]
        pc_stage_one_q == $past(alu_result))
        else $error("first stage missed the ALU result");

    pca_hold_a: assert property (!(phase_t5 && pc_stage_one_load) |=> // [RULE1]
        $stable(pc_stage_one_q))
        else $error("first stage changed without a T5 load");

    pcb_copy_a: assert property (phase_t1 && pc_stage_two_code == PCB_ALWAYS |=> // [RULE2]
        pc_stage_two_q == $past(pc_stage_one_q))
        else $error("second stage missed an unconditional load");

    pcb_block_a: assert property (phase_t1 && pc_stage_two_code == PCB_IF_DST // [RULE2]
        && i_class && microword_write_qualifier |=> $stable(pc_stage_two_q))
        else $error("second stage loaded for a qualified class write");

    pad_off_a: assert property (addr_select == PAD_OFF |-> // [RULE12]
        src_reg_index[2:0] == 3'h0 && dst_reg_index[2:0] == 3'h0)
        else $error("index bits not low with multiplexers off");

    const_c_a: assert property (addr_select == PAD_CC |-> // [RULE17]
        src_reg_index[2:0] == IDX_C && dst_reg_index[2:0] == IDX_C)
        else $error("input C is not index five");

    stack_d_a: assert property (addr_select == PAD_DD |-> // [RULE18]
        dst_reg_index[2:0] == {2'b11, status_word[PS_CUR_HI]})
        else $error("input D stack index wrong");

    user_sp_a: assert property (addr_select == PAD_AA && !console_q // [RULE4]
        && src_field == IDX_SP && mode_cur_hi && mode_super_user
        |-> src_reg_index == 4'hF)
        else $error("user stack pointer not at register seventeen");

    odd_pair_a: assert property (addr_select == PAD_ODD && force_odd_index // [RULE15]
        |-> src_reg_index[0])
        else $error("force odd did not set index bit zero");

    pc_read_a: assert property (src_field == IDX_PC && addr_select == PAD_AA // [RULE9]
        |-> src_read_data == pc_stage_two_q)
        else $error("register seven read did not return the counter");

    copy_match_a: assert property (!rif.wr_lo_n && !rif.wr_hi_n // [RULE7]
        |=> u_store.src_copy_q[$past(rif.dst_addr)]
            == u_store.dst_copy_q[$past(rif.dst_addr)])
        else $error("storage copies differ after a write");

    pc_write_drop_a: assert property (dst_route[4] && !low_byte_write_enable_n // [RULE3]
        |=> u_store.dst_copy_q[$past(rif.dst_addr)]
            == $past(u_store.dst_copy_q[rif.dst_addr]))
        else $error("a write aimed at the counter reached storage");

    set_select_a: assert property (addr_select == PAD_AA && !console_q // [RULE5]
        && !move_previous && src_field < IDX_SP |-> src_reg_index[3] == reg_set)
        else $error("low registers ignored the set bit");

    b_even_a: assert property (addr_select == PAD_BB && !console_q // [RULE16]
        && !instruction_reg[0] |-> !dst_reg_index[0])
        else $error("input B bit zero set outside console use");

    pcb_src_a: assert property (phase_t1 && pc_stage_two_code == PCB_IF_SRC // [RULE2]
        && src_field != IDX_PC |=> $stable(pc_stage_two_q))
        else $error("second stage loaded without source field seven");

endmodule : pgr_top

// ==== sim/pgr_phase_gen.sv ====
// Model of the machine timing that feeds the block its T1 and T5 phase pulses.
// Assumes the block samples both pulses at the rising edge of pclk.
module pgr_phase_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic phase_t1,
    output logic phase_t5
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    // A slow machine cycle stretches the gap after T5, as a stalled memory access would.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            phase_t1 <= 1'b0;
            phase_t5 <= 1'b0;
        end else begin
            cnt_q <= (cnt_q >= (slow ? 4'h9 : 4'h5)) ? 4'h0 : cnt_q + 4'h1;
            phase_t1 <= (cnt_q == 4'h0);
            phase_t5 <= (cnt_q == 4'h3);
        end
    end
endmodule : pgr_phase_gen

// ==== sim/pgr_top_tb.sv ====
// Self-checking bench for the counter stages and the general register file.
// Assumes the phase model on pclk and APB access to the control registers.
module pgr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pgr_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, sidx, didx;
    logic pready, pslverr, t1, t5, s1, s2, err;
    logic slow = 1'b0, ld1 = 1'b0, icl = 1'b0, wq = 1'b0, mp = 1'b0, fo = 1'b0;
    logic wlo_n = 1'b1, whi_n = 1'b1;
    logic [1:0] code = 2'h0;
    logic [2:0] pad = 3'h0;
    logic [15:0] alu = 16'h0, ir = 16'h0, ps = 16'h0, shf = 16'h0, pc2, srd, drd;
    logic [15:0] e1 = 16'h0, e2 = 16'h0;
    logic [15:0] img [16];
    logic [4:0] e;
    logic [1:0] cdv [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0};
    logic [15:0] irv [6] = '{16'h01C0, 16'h0140, 16'h0007, 16'h0007, 16'h0007, 16'h01C7};
    logic [1:0] qv [6] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h0};
    logic [15:0] psm [3] = '{16'h0000, 16'h4000, 16'hC000};
    logic [3:0] spx [3] = '{4'h6, 4'hE, 4'hF};
    logic [15:0] civ [5] = '{16'h0102, 16'h0186, 16'h0106, 16'h0186, 16'h0106};
    logic [15:0] cps [5] = '{16'h0800, 16'hC000, 16'h2000, 16'hC000, 16'h4000};
    logic cfo [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic ccon [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    logic cmp [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    int miscompares = 0, tests_run = 0;

    always #25 pclk = ~pclk;

    pgr_phase_gen PHASE (.pclk(pclk), .presetn(presetn), .slow(slow), .phase_t1(t1),
        .phase_t5(t5));
    pgr_top DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_t1(t1), .phase_t5(t5), .alu_result(alu),
        .pc_stage_one_load(ld1), .pc_stage_two_code(code), .instruction_reg(ir), .i_class(icl),
        .microword_write_qualifier(wq), .move_previous(mp), .status_word(ps),
        .addr_select(pad), .force_odd_index(fo), .low_byte_write_enable_n(wlo_n),
        .high_byte_write_enable_n(whi_n), .shifter_unit(shf), .pc_stage_two(pc2),
        .src_read_data(srd), .dst_read_data(drd), .src_reg_index(sidx), .dst_reg_index(didx),
        .first_stage_load_strobe(s1), .second_stage_load_strobe(s2)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic hang;
        miscompares++;
        $display("Error at %0t: wait ran out", $time);
        print_verdict();
    endtask : hang

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Read data and the error flag are taken at the edge that sees pready high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        logic ok;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            ok = pready;
            rd = prdata;
            err = pslverr;
            n++;
        end while (ok !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (ok !== 1'b1) hang();
    endtask : apb

    task automatic look(input logic [2:0] p, input logic [15:0] i, input logic [15:0] s);
        @(posedge pclk);
        pad <= p;
        ir <= i;
        ps <= s;
        @(negedge pclk);
    endtask : look

    // Bit 4 of the target marks a write routed to the counter, which must be dropped.
    task automatic wreg(input logic [2:0] p, input logic [15:0] i, input logic [15:0] s,
        input logic [4:0] a, input logic [15:0] v, input logic lo_n, input logic hi_n);
        look(p, i, s);
        chk(drd, a[4] ? e2 : img[a[3:0]]);
        if (!a[4]) chk(didx, a[3:0]);
        @(posedge pclk);
        shf <= v;
        wlo_n <= lo_n;
        whi_n <= hi_n;
        @(posedge pclk);
        wlo_n <= 1'b1;
        whi_n <= 1'b1;
        if (!a[4] && !lo_n) img[a[3:0]][7:0] = v[7:0];
        if (!a[4] && !hi_n) img[a[3:0]][15:8] = v[15:8];
    endtask : wreg

    ////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic pc2_ld();
        return (code == 2'h1) || (code == 2'h2 && ir[8:6] == 3'h7) ||
            (code == 2'h3 && ir[2:0] == 3'h7 && !(icl && wq));
    endfunction : pc2_ld

    task automatic mcycle;
        int n = 0;
        bit g5 = 1'b0;
        bit g1 = 1'b0;
        while (!g1 && n < 40) begin
            @(negedge pclk);
            chk(s1, t5 & ld1);
            chk(s2, t1 & pc2_ld());
            if (t1 === 1'b1 && pc2_ld()) e2 = e1;
            if (t1 === 1'b1 && g5) g1 = 1'b1;
            if (t5 === 1'b1 && ld1) e1 = alu;
            if (t5 === 1'b1) g5 = 1'b1;
            @(posedge pclk);
            n++;
        end
        if (!g1) hang();
        @(negedge pclk);
        chk(pc2, e2);
        @(posedge pclk);
    endtask : mcycle

    // Bit 4 of the result says whether the set bit is defined for this case.
    function automatic logic [4:0] eidx(input logic [2:0] p, input logic d, input logic c);
        logic [2:0] fa;
        logic [2:0] fb;
        fa = ir[8:6];
        fb = ir[2:0];
        if (p == 3'h2 || p == 3'h6) return {1'b1, ps[11], (p == 3'h6) ? 3'h0 : 3'h5};
        if (p == 3'h7) return {1'b1, ps[14], 2'b11, ps[15]};
        if (p == 3'h5 || (p == 3'h1 && d))
            return {!c && !mp && fb != 3'h7, (fb < 3'h6) ? ps[11] : ps[14], fb[2:1],
                fb[0] | (c && fb == 3'h6 && ((mp && ir[5:3] == 3'h0) ? ps[13] : ps[15]))};
        return {!c && fa != 3'h7, (fa < 3'h6) ? ps[11] : ps[14], fa[2:1],
            fa[0] | (ps[15] && fa[2:1] == 2'b11) | (p == 3'h4 && fo)};
    endfunction : eidx

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int k = 0; k < 16; k++) img[k] = 16'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFS_PC1, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, OFS_PC2, 32'hFFFF);
        apb(1'b0, OFS_PC2, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h0);
        alu <= 16'h1234;
        ld1 <= 1'b1;
        mcycle();
        ld1 <= 1'b0;
        alu <= 16'hFFFF;
        code <= 2'h1;
        mcycle();
        apb(1'b0, OFS_PC1, 32'h0);
        chk(rd, {16'h0, e1});
        for (int k = 0; k < 6; k++) begin
            ld1 <= 1'b1;
            alu <= 16'h2000 + 16'(k);
            code <= cdv[k];
            ir <= irv[k];
            {icl, wq} <= qv[k];
            slow <= k[0];
            mcycle();
        end
        ld1 <= 1'b0;
        code <= 2'h0;
        for (int s = 0; s < 2; s++)
            for (int f = 0; f < 6; f++)
                wreg(3'h5, 16'(f), s ? 16'h0800 : 16'h0, 5'(s * 8 + f), 16'hA500 + 16'(s * 16 + f),
                    1'b0, 1'b0);
        for (int m = 0; m < 3; m++)
            wreg(3'h7, 16'h0, psm[m], {1'b0, spx[m]}, 16'h5A00 + 16'(m), 1'b0, 1'b0);
        wreg(3'h5, 16'h0002, 16'h0, 5'h02, 16'h1234, 1'b0, 1'b1);
        wreg(3'h5, 16'h0002, 16'h0, 5'h02, 16'h5678, 1'b1, 1'b0);
        wreg(3'h5, 16'h0002, 16'h0, 5'h02, 16'h9999, 1'b1, 1'b1);
        wreg(3'h5, 16'h0007, 16'hC000, 5'h10, 16'hDEAD, 1'b0, 1'b0);
        look(3'h7, 16'h0, 16'h8000);
        chk(srd, img[7]);
        for (int s = 0; s < 2; s++)
            for (int f = 0; f < 6; f++) begin
                look(3'h1, 16'((5 - f) << 6 | f), s ? 16'h0800 : 16'h0);
                chk(srd, img[s * 8 + 5 - f]);
                chk(drd, img[s * 8 + f]);
            end
        for (int m = 0; m < 3; m++) begin
            look(3'h0, 16'h0180, psm[m]);
            chk(srd, img[spx[m]]);
            chk(drd, img[spx[m]]);
        end
        look(3'h0, 16'h01C0, 16'h0);
        chk(srd, e2);
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, OFS_CTRL, {31'h0, ccon[c]});
            fo <= cfo[c];
            mp <= cmp[c];
            for (int p = 0; p < 8; p++) begin
                // Select code three is never issued by the microprogram.
                if (p != 3) begin
                    look(3'(p), civ[c], cps[c]);
                    e = eidx(3'(p), 1'b0, ccon[c]);
                    chk(sidx & {e[4], 3'h7}, e[3:0] & {e[4], 3'h7});
                    e = eidx(3'(p), 1'b1, ccon[c]);
                    chk(didx & {e[4], 3'h7}, e[3:0] & {e[4], 3'h7});
                end
            end
        end
        print_verdict();
    end
endmodule : pgr_top_tb
